/* File: design/icu_main.sv */
// The address map and the APB slave port are this design's own decisions.
`timescale 1ns/1ps

module icu_main
  import icu_pkg::*;
#(
  parameter int PB_W     = ICU_PB_W,
  parameter int CYC_CLKS = ICU_OSC_PER_IC
) (
  input  wire logic            clk,
  input  wire logic            rstn,
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [11:0]     paddr,
  input  wire logic [31:0]     pwdata,
  output logic      [31:0]     prdata,
  output logic                 pready,
  output logic                 pslverr,
  input  wire logic            ext_irq_pin,
  input  wire logic [PB_W-1:0] port_b_upper_pins,
  input  wire logic            timer_zero_ovf,
  input  wire logic            cmp_change,
  input  wire logic            return_from_irq_instr,
  input  wire logic            gie_clear_instr,
  output logic                 core_irq_req,
  output logic                 stack_push,
  output logic                 pc_load,
  output logic      [12:0]     program_counter,
  output logic                 nop_insert,
  output logic                 instr_bnd,
  output logic                 irq
);

  typedef struct packed {
    logic [7:0]  ctl;
    logic [7:0]  pflag;
    logic [7:0]  pen;
    logic [1:0]  ist;
    logic [1:0]  ien;
    logic        pend;
    logic        nop;
    icu_seq_t    st;
    logic        push;
    logic        load;
    logic [12:0] pc;
    logic [31:0] rdata;
  } icu_state_t;

  icu_state_t s_r;
  icu_state_t s_nxt;

  logic ext_evt;
  logic pb_evt;
  logic tmr_evt;
  logic cmp_evt;
  logic bnd;
  logic wr;
  logic setup;
  logic mapped;
  logic any_req;
  logic take;

  // ----------------------------------------------------------------
  // Instruction cycle timing and source detection.
  // ----------------------------------------------------------------
  icu_phase_gen #(
    .CYC_CLKS (CYC_CLKS)
  ) u_phase (
    .clk  (clk),
    .rstn (rstn),
    .bnd  (bnd)
  );

  icu_src_detect #(
    .PB_W (PB_W)
  ) u_det (
    .clk               (clk),
    .rstn              (rstn),
    .ext_irq_pin       (ext_irq_pin),
    .port_b_upper_pins (port_b_upper_pins),
    .timer_zero_ovf    (timer_zero_ovf),
    .cmp_change        (cmp_change),
    .ext_evt           (ext_evt),
    .pb_evt            (pb_evt),
    .tmr_evt           (tmr_evt),
    .cmp_evt           (cmp_evt)
  );

  // ----------------------------------------------------------------
  // Register decode.
  // ----------------------------------------------------------------
  function automatic logic is_mapped(input logic [11:0] a);
    is_mapped = (a == ICU_OFF_CTL) || (a == ICU_OFF_PFLAG) || (a == ICU_OFF_PEN) ||
                (a == ICU_OFF_ISTAT) || (a == ICU_OFF_ICLR) || (a == ICU_OFF_IEN);
  endfunction

  function automatic logic [31:0] rd_mux(input icu_state_t s, input logic [11:0] a);
    rd_mux = '0;
    unique case (a)
      ICU_OFF_CTL:   rd_mux[7:0] = s.ctl;
      ICU_OFF_PFLAG: rd_mux[7:0] = s.pflag;
      ICU_OFF_PEN:   rd_mux[7:0] = s.pen;
      ICU_OFF_ISTAT: rd_mux[1:0] = s.ist;
      ICU_OFF_IEN:   rd_mux[1:0] = s.ien;
      default:       rd_mux      = '0;
    endcase
  endfunction

  assign setup  = psel & ~penable;
  assign wr     = psel & penable & pwrite;
  assign mapped = is_mapped(paddr);

  // ----------------------------------------------------------------
  // Request combine.
  // ----------------------------------------------------------------
  always_comb begin
    any_req = (s_r.ctl[ICU_EXT_FLG_BIT] & s_r.ctl[ICU_EXT_EN_BIT]) |
              (s_r.ctl[ICU_PB_FLG_BIT]  & s_r.ctl[ICU_PB_EN_BIT])  |
              (s_r.ctl[ICU_TMR_FLG_BIT] & s_r.ctl[ICU_TMR_EN_BIT]) |
              (s_r.ctl[ICU_PER_EN_BIT]  & s_r.pflag[ICU_CMP_BIT] & s_r.pen[ICU_CMP_BIT]);
  end

  assign core_irq_req = any_req & s_r.ctl[ICU_GIE_BIT];
  assign take = bnd & s_r.pend & s_r.ctl[ICU_GIE_BIT] & (s_r.st == ICU_RUN) &
                ~s_r.nop & ~gie_clear_instr;

  // ----------------------------------------------------------------
  // Next state.
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt      = s_r;
    s_nxt.push = 1'b0;
    s_nxt.load = 1'b0;
    if (setup) begin
      s_nxt.rdata = rd_mux(s_r, paddr);
    end
    if (wr) begin
      unique case (paddr)
        ICU_OFF_CTL:   s_nxt.ctl   = pwdata[7:0];
        ICU_OFF_PFLAG: s_nxt.pflag = pwdata[7:0];
        ICU_OFF_PEN:   s_nxt.pen   = pwdata[7:0];
        ICU_OFF_ICLR:  s_nxt.ist   = s_r.ist & ~pwdata[1:0];
        ICU_OFF_IEN:   s_nxt.ien   = pwdata[1:0];
        default:       s_nxt.ien   = s_r.ien;
      endcase
    end
    if (bnd) begin
      s_nxt.pend = core_irq_req;
      s_nxt.nop  = 1'b0;
    end
    if (bnd && gie_clear_instr) begin
      s_nxt.ctl[ICU_GIE_BIT] = 1'b0;
      s_nxt.nop              = 1'b1;
      if (s_r.pend) begin
        s_nxt.ist[ICU_EV_SUPP] = 1'b1;
      end
    end
    if (bnd && return_from_irq_instr) begin
      s_nxt.ctl[ICU_GIE_BIT] = 1'b1;
    end
    unique case (s_r.st)
      ICU_RUN: begin
        if (take) begin
          s_nxt.st                = ICU_DUMMY;
          s_nxt.ctl[ICU_GIE_BIT]  = 1'b0;
          s_nxt.push              = 1'b1;
          s_nxt.ist[ICU_EV_TAKEN] = 1'b1;
        end
      end
      ICU_DUMMY: begin
        if (bnd) begin
          s_nxt.st   = ICU_VEC;
          s_nxt.load = 1'b1;
          s_nxt.pc   = ICU_VECTOR;
        end
      end
      ICU_VEC: begin
        s_nxt.st = ICU_RUN;
      end
      default: begin
        s_nxt.st = ICU_RUN;
      end
    endcase
    // Hardware events win over software clears in the same cycle.
    if (ext_evt) begin
      s_nxt.ctl[ICU_EXT_FLG_BIT] = 1'b1;
    end
    if (pb_evt) begin
      s_nxt.ctl[ICU_PB_FLG_BIT] = 1'b1;
    end
    if (tmr_evt) begin
      s_nxt.ctl[ICU_TMR_FLG_BIT] = 1'b1;
    end
    if (cmp_evt) begin
      s_nxt.pflag[ICU_CMP_BIT] = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_r.ctl   <= ICU_CTL_RST;
      s_r.pflag <= ICU_PER_RST;
      s_r.pen   <= ICU_PER_RST;
      s_r.ist   <= ICU_EV_RST;
      s_r.ien   <= ICU_EV_RST;
      s_r.pend  <= 1'b0;
      s_r.nop   <= 1'b0;
      s_r.st    <= ICU_RUN;
      s_r.push  <= 1'b0;
      s_r.load  <= 1'b0;
      s_r.pc    <= '0;
      s_r.rdata <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs.
  // ----------------------------------------------------------------
  assign prdata          = s_r.rdata;
  assign pready          = psel & penable;
  assign pslverr         = psel & penable & ~mapped;
  assign stack_push      = s_r.push;
  assign pc_load         = s_r.load;
  assign program_counter = s_r.pc;
  assign nop_insert      = s_r.nop;
  assign instr_bnd       = bnd;
  assign irq             = |(s_r.ist & s_r.ien);

  // ----------------------------------------------------------------
  // Assertions.
  // ----------------------------------------------------------------
  property p_gie_blocks;
    @(posedge clk) disable iff (!rstn)
      !s_r.ctl[ICU_GIE_BIT] |=> !s_r.push;
  endproperty
  a_gie_blocks: assert property (p_gie_blocks) else $error("interrupt taken with global enable clear");

  property p_src_mask;
    @(posedge clk) disable iff (!rstn)
      (s_r.ctl[ICU_EXT_FLG_BIT] && !s_r.ctl[ICU_EXT_EN_BIT] && !s_r.ctl[ICU_PB_FLG_BIT] &&
       !s_r.ctl[ICU_TMR_FLG_BIT] && !s_r.pflag[ICU_CMP_BIT]) |-> !core_irq_req;
  endproperty
  a_src_mask: assert property (p_src_mask) else $error("masked source raised a request");

  property p_return_from_irq_instr;
    @(posedge clk) disable iff (!rstn)
      (bnd && return_from_irq_instr && !take) |=> s_r.ctl[ICU_GIE_BIT];
  endproperty
  a_return_from_irq_instr: assert property (p_return_from_irq_instr) else $error("return did not set global enable");

  property p_take_seq;
    @(posedge clk) disable iff (!rstn)
      take |=> (stack_push && !s_r.ctl[ICU_GIE_BIT]) ##[1:4] (pc_load && program_counter == ICU_VECTOR);
  endproperty
  a_take_seq: assert property (p_take_seq) else $error("vector sequence wrong");

  property p_latency;
    @(posedge clk) disable iff (!rstn)
      (ext_evt && s_r.ctl[ICU_EXT_EN_BIT] && s_r.ctl[ICU_GIE_BIT] && s_r.st == ICU_RUN && !s_r.nop)
        |-> ##[1:17] (stack_push || !s_r.ctl[ICU_GIE_BIT]);
  endproperty
  a_latency: assert property (p_latency) else $error("external event not serviced in time");

  property p_flag_set;
    @(posedge clk) disable iff (!rstn)
      tmr_evt |=> s_r.ctl[ICU_TMR_FLG_BIT];
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("timer flag not set on event");

  property p_nop;
    @(posedge clk) disable iff (!rstn)
      (bnd && gie_clear_instr) |=> (nop_insert && !stack_push) [*4];
  endproperty
  a_nop: assert property (p_nop) else $error("no-op cycle missing after enable clear");

  property p_pending;
    @(posedge clk) disable iff (!rstn)
      (nop_insert && s_r.ctl[ICU_EXT_FLG_BIT] && !wr) |=> s_r.ctl[ICU_EXT_FLG_BIT];
  endproperty
  a_pending: assert property (p_pending) else $error("suppressed request lost");

  property p_cycle;
    @(posedge clk) disable iff (!rstn)
      bnd |=> !bnd [*3] ##1 bnd;
  endproperty
  a_cycle: assert property (p_cycle) else $error("instruction cycle not four clocks");

  property p_ext_flag;
    @(posedge clk) disable iff (!rstn)
      ext_evt |=> s_r.ctl[ICU_EXT_FLG_BIT];
  endproperty
  a_ext_flag: assert property (p_ext_flag) else $error("pin flag not set on edge");

  property p_pb_flag;
    @(posedge clk) disable iff (!rstn)
      pb_evt |=> s_r.ctl[ICU_PB_FLG_BIT];
  endproperty
  a_pb_flag: assert property (p_pb_flag) else $error("port change flag not set");

  property p_cmp_flag;
    @(posedge clk) disable iff (!rstn)
      cmp_evt |=> s_r.pflag[ICU_CMP_BIT];
  endproperty
  a_cmp_flag: assert property (p_cmp_flag) else $error("comparator flag not set");

  property p_vec_load;
    @(posedge clk) disable iff (!rstn)
      pc_load |-> (program_counter == ICU_VECTOR);
  endproperty
  a_vec_load: assert property (p_vec_load) else $error("vector load with wrong address");

  property p_push_once;
    @(posedge clk) disable iff (!rstn)
      stack_push |=> !stack_push;
  endproperty
  a_push_once: assert property (p_push_once) else $error("return address pushed twice");

  property p_req_combine;
    @(posedge clk) disable iff (!rstn)
      (s_r.ctl[ICU_GIE_BIT] && s_r.ctl[ICU_EXT_FLG_BIT] && s_r.ctl[ICU_EXT_EN_BIT]) |-> core_irq_req;
  endproperty
  a_req_combine: assert property (p_req_combine) else $error("enabled pin flag raised no request");

  property p_per_path;
    @(posedge clk) disable iff (!rstn)
      (s_r.ctl[ICU_GIE_BIT] && s_r.ctl[ICU_PER_EN_BIT] && s_r.pflag[ICU_CMP_BIT] && s_r.pen[ICU_CMP_BIT])
        |-> core_irq_req;
  endproperty
  a_per_path: assert property (p_per_path) else $error("peripheral path raised no request");

  property p_gie_clear;
    @(posedge clk) disable iff (!rstn)
      (bnd && gie_clear_instr && !return_from_irq_instr) |=> !s_r.ctl[ICU_GIE_BIT];
  endproperty
  a_gie_clear: assert property (p_gie_clear) else $error("enable clear instruction ignored");

endmodule

/* File: design/icu_pkg.sv */
package icu_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets.
  // ----------------------------------------------------------------
  localparam logic [11:0] ICU_OFF_CTL    = 12'h000;
  localparam logic [11:0] ICU_OFF_PFLAG  = 12'h004;
  localparam logic [11:0] ICU_OFF_PEN    = 12'h008;
  localparam logic [11:0] ICU_OFF_ISTAT  = 12'h00c;
  localparam logic [11:0] ICU_OFF_ICLR   = 12'h010;
  localparam logic [11:0] ICU_OFF_IEN    = 12'h014;

  // ----------------------------------------------------------------
  // Field positions of the interrupt control, peripheral flag/enable and status registers.
  // ----------------------------------------------------------------
  localparam int ICU_GIE_BIT     = 7;
  localparam int ICU_PER_EN_BIT  = 6;
  localparam int ICU_TMR_EN_BIT  = 5;
  localparam int ICU_EXT_EN_BIT  = 4;
  localparam int ICU_PB_EN_BIT   = 3;
  localparam int ICU_TMR_FLG_BIT = 2;
  localparam int ICU_EXT_FLG_BIT = 1;
  localparam int ICU_PB_FLG_BIT  = 0;
  localparam int ICU_CMP_BIT     = 0;
  localparam int ICU_EV_TAKEN    = 0;
  localparam int ICU_EV_SUPP     = 1;

  // ----------------------------------------------------------------
  // Reset values, vector and timing.
  // ----------------------------------------------------------------
  localparam logic [7:0]  ICU_CTL_RST    = 8'h00;
  localparam logic [7:0]  ICU_PER_RST    = 8'h00;
  localparam logic [1:0]  ICU_EV_RST     = 2'h0;
  localparam logic [12:0] ICU_VECTOR     = 13'h0004;
  localparam int          ICU_OSC_PER_IC = 4;
  localparam int          ICU_N_SRC      = 4;
  localparam int          ICU_PB_W       = 4;

  typedef enum logic [2:0] {
    ICU_RUN   = 3'b001,
    ICU_DUMMY = 3'b010,
    ICU_VEC   = 3'b100
  } icu_seq_t;

endpackage

/* File: design/icu_phase_gen.sv */
`timescale 1ns/1ps

module icu_phase_gen
  import icu_pkg::*;
#(
  parameter int CYC_CLKS = ICU_OSC_PER_IC
) (
  input  wire logic clk,
  input  wire logic rstn,
  output logic      bnd
);

  typedef struct packed {
    logic [1:0] cnt;
  } icu_ph_t;

  icu_ph_t ph_r;
  icu_ph_t ph_nxt;

  // ----------------------------------------------------------------
  // Instruction cycle counter, one boundary per cycle.
  // ----------------------------------------------------------------
  always_comb begin
    ph_nxt = ph_r;
    if (ph_r.cnt == 2'(CYC_CLKS - 1)) begin
      ph_nxt.cnt = 2'h0;
    end else begin
      ph_nxt.cnt = ph_r.cnt + 2'h1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ph_r <= '0;
    end else begin
      ph_r <= ph_nxt;
    end
  end

  assign bnd = (ph_r.cnt == 2'(CYC_CLKS - 1));

endmodule

/* File: design/icu_src_detect.sv */
`timescale 1ns/1ps

module icu_src_detect
  import icu_pkg::*;
#(
  parameter int PB_W = ICU_PB_W
) (
  input  wire logic            clk,
  input  wire logic            rstn,
  input  wire logic            ext_irq_pin,
  input  wire logic [PB_W-1:0] port_b_upper_pins,
  input  wire logic            timer_zero_ovf,
  input  wire logic            cmp_change,
  output logic                 ext_evt,
  output logic                 pb_evt,
  output logic                 tmr_evt,
  output logic                 cmp_evt
);

  typedef struct packed {
    logic            ext;
    logic [PB_W-1:0] pb;
    logic            armed;
  } icu_det_t;

  icu_det_t d_r;
  icu_det_t d_nxt;

  // ----------------------------------------------------------------
  // Previous pin levels for edge and change detection.
  // ----------------------------------------------------------------
  always_comb begin
    d_nxt       = d_r;
    d_nxt.ext   = ext_irq_pin;
    d_nxt.pb    = port_b_upper_pins;
    d_nxt.armed = 1'b1;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      d_r <= '0;
    end else begin
      d_r <= d_nxt;
    end
  end

  // Four sources: pin rising edge, timer overflow, port change, comparator.
  assign ext_evt = ext_irq_pin & ~d_r.ext & d_r.armed;
  assign pb_evt  = d_r.armed & (port_b_upper_pins != d_r.pb);
  assign tmr_evt = timer_zero_ovf;
  assign cmp_evt = cmp_change;

endmodule

/* File: sim/icu_core_model.sv */
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Core sequencer model: executes return and enable-clear opcodes.
// ----------------------------------------------------------------
module icu_core_model (
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic instr_bnd,
  input  wire logic stack_push,
  input  wire logic pc_load,
  input  wire logic req_ret,
  input  wire logic req_clr,
  output logic      return_from_irq_instr,
  output logic      gie_clear_instr,
  output int        push_n,
  output int        load_n
);
  // An opcode stays up until a cycle boundary consumes it.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      return_from_irq_instr <= 1'b0;
      gie_clear_instr       <= 1'b0;
      push_n                <= 0;
      load_n                <= 0;
    end else begin
      return_from_irq_instr <= (return_from_irq_instr & ~instr_bnd) | req_ret;
      gie_clear_instr       <= (gie_clear_instr & ~instr_bnd) | req_clr;
      push_n                <= push_n + int'(stack_push);
      load_n                <= load_n + int'(pc_load);
    end
  end
endmodule

/* File: sim/test_interrupt_control_unit.sv */
`timescale 1ns/1ps

module test_interrupt_control_unit;
  import icu_pkg::*;
  logic clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, r;
  logic ext = 0, tmr = 0, cmp = 0, ret, clr, req_ret = 0, req_clr = 0, err;
  logic [3:0] pb = 4'h0;
  logic core_irq_req, stack_push, pc_load, nop_insert, instr_bnd, irq;
  logic [12:0] program_counter;
  int fails = 0, check_count = 0, push_n, load_n, n, p0;

  always #2 clk = ~clk;

  icu_main dut_u (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_irq_pin(ext), .port_b_upper_pins(pb), .timer_zero_ovf(tmr), .cmp_change(cmp),
    .return_from_irq_instr(ret), .gie_clear_instr(clr), .core_irq_req(core_irq_req),
    .stack_push(stack_push), .pc_load(pc_load), .program_counter(program_counter),
    .nop_insert(nop_insert), .instr_bnd(instr_bnd), .irq(irq));

  icu_core_model core_u (.clk(clk), .rstn(rstn), .instr_bnd(instr_bnd), .stack_push(stack_push),
    .pc_load(pc_load), .req_ret(req_ret), .req_clr(req_clr), .return_from_irq_instr(ret),
    .gie_clear_instr(clr), .push_n(push_n), .load_n(load_n));

  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask

  // ----------------------------------------------------------------
  // APB master: setup, access until pready, then release.
  // ----------------------------------------------------------------
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task clks(input int k);
    repeat (k) @(posedge clk);
  endtask

  task wait_load(input int lim);
    n = 0;
    while (pc_load !== 1'b1 && n < lim) begin
      @(posedge clk);
      n++;
    end
  endtask

  // ----------------------------------------------------------------
  // Scenarios.
  // ----------------------------------------------------------------
  task t_reset;
    apb(0, ICU_OFF_CTL, 0);
    chk("ctl rst", r, 32'h0000_0000);
    apb(0, ICU_OFF_PEN, 0);
    chk("pen rst", r, 32'h0000_0000);
    apb(0, 12'h020, 0);
    chk("unmapped err", {31'h0, err}, 32'h0000_0001);
    chk("unmapped data", r, 32'h0000_0000);
  endtask

  task t_phase;
    while (instr_bnd !== 1'b1) @(posedge clk);
    @(posedge clk);
    n = 1;
    while (instr_bnd !== 1'b1 && n < 10) begin
      @(posedge clk);
      n++;
    end
    chk("cycle clocks", n, ICU_OSC_PER_IC);
  endtask

  task t_flags;
    ext <= 1'b1;
    pb <= 4'h8;
    tmr <= 1'b1;
    cmp <= 1'b1;
    @(posedge clk);
    tmr <= 1'b0;
    cmp <= 1'b0;
    ext <= 1'b0;
    clks(2);
    apb(0, ICU_OFF_CTL, 0);
    chk("ctl flags", r, 32'h0000_0007);
    apb(0, ICU_OFF_PFLAG, 0);
    chk("cmp flag", r, 32'h0000_0001);
    chk("req no gie", core_irq_req, 1'b0);
  endtask

  task t_mask;
    apb(1, ICU_OFF_PFLAG, 32'h0000_0000);
    apb(1, ICU_OFF_CTL, 32'h0000_008a);
    clks(1);
    chk("req masked", core_irq_req, 1'b0);
    apb(1, ICU_OFF_PFLAG, 32'h0000_0001);
    apb(1, ICU_OFF_PEN, 32'h0000_0001);
    apb(1, ICU_OFF_CTL, 32'h0000_00c0);
    clks(1);
    chk("req per", core_irq_req, 1'b1);
    apb(1, ICU_OFF_CTL, 32'h0000_0000);
    apb(1, ICU_OFF_PFLAG, 32'h0000_0000);
  endtask

  task t_take;
    p0 = push_n;
    apb(1, ICU_OFF_CTL, 32'h0000_0090);
    clks(3);
    ext <= 1'b1;
    @(posedge clk);
    wait_load(40);
    chk("latency", {31'h0, n >= 8 && n <= 17}, 32'h0000_0001);
    @(posedge clk);
    chk("vector", program_counter, ICU_VECTOR);
    chk("push", push_n, p0 + 1);
    apb(0, ICU_OFF_CTL, 0);
    chk("gie off", r, 32'h0000_0012);
    apb(0, ICU_OFF_ISTAT, 0);
    chk("taken stat", r[0], 1'b1);
    chk("irq masked", irq, 1'b0);
    apb(1, ICU_OFF_IEN, 32'h0000_0001);
    clks(1);
    chk("irq on", irq, 1'b1);
    apb(1, ICU_OFF_ICLR, 32'h0000_0003);
    clks(1);
    chk("irq clr", irq, 1'b0);
    ext <= 1'b0;
  endtask

  task t_ret;
    apb(1, ICU_OFF_CTL, 32'h0000_0010);
    req_ret <= 1'b1;
    @(posedge clk);
    req_ret <= 1'b0;
    @(posedge clk);
    while (ret === 1'b1) @(posedge clk);
    clks(2);
    apb(0, ICU_OFF_CTL, 0);
    chk("gie back", r, 32'h0000_0090);
  endtask

  task t_supp;
    p0 = push_n;
    ext <= 1'b1;
    clks(2);
    while (instr_bnd !== 1'b1) @(posedge clk);
    req_clr <= 1'b1;
    @(posedge clk);
    req_clr <= 1'b0;
    n = 0;
    while (nop_insert !== 1'b1 && n < 16) begin
      @(posedge clk);
      n++;
    end
    chk("nop", nop_insert, 1'b1);
    apb(1, ICU_OFF_CTL, 32'h0000_0012);
    chk("no take", push_n, p0);
    apb(0, ICU_OFF_ISTAT, 0);
    chk("supp stat", r, 32'h0000_0002);
    apb(1, ICU_OFF_CTL, 32'h0000_0092);
    wait_load(40);
    chk("pending taken", pc_load, 1'b1);
    ext <= 1'b0;
  endtask

  task results;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    #20000;
    fails++;
    results();
  end

  initial begin
    clks(16);
    rstn <= 1'b1;
    t_reset();
    t_phase();
    t_flags();
    t_mask();
    t_take();
    t_ret();
    t_supp();
    results();
  end
endmodule
